// ---- include/sdgc_pkg.sv ----
// constants, types and register map of the system clock divider go control
// assumes a classic wishbone master and one clock that stands for the divider source
package sdgc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [31:0] SDGC_ADDR_CMD   = 32'h029a_0138;
  localparam logic [31:0] SDGC_ADDR_STAT  = 32'h029a_013c;
  localparam logic [31:0] SDGC_ADDR_ALN   = 32'h029a_0140;
  localparam logic [31:0] SDGC_ADDR_CHG   = 32'h029a_0144;
  localparam logic [31:0] SDGC_ADDR_CLKON = 32'h029a_0150;
  localparam logic [31:0] SDGC_ADDR_DIV4  = 32'h029a_0160;
  localparam logic [31:0] SDGC_ADDR_DIV5  = 32'h029a_0164;
  localparam logic [31:0] SDGC_ADDR_IST   = 32'h029a_0170;
  localparam logic [31:0] SDGC_ADDR_IMSK  = 32'h029a_0174;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SDGC_EN_POS   = 15;
  localparam int SDGC_ALN4_POS = 3;
  localparam int SDGC_CHG4_POS = 3;
  localparam int SDGC_ON4_POS  = 3;
  localparam int SDGC_ON1_POS  = 1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic       SDGC_RST_EN    = 1'b1;
  localparam logic [4:0] SDGC_RST_RATIO = 5'h0_0;
  localparam logic [1:0] SDGC_RST_ALN   = 2'h3;
  localparam logic [1:0] SDGC_RST_IMSK  = 2'h0;

  typedef enum logic [2:0] {
    SDGC_ST_IDLE  = 3'b001,
    SDGC_ST_APPLY = 3'b010,
    SDGC_ST_DONE  = 3'b100
  } sdgc_state_e;

  // index 1 is the fifth clock, index 0 the fourth
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } sdgc_wb_req_s;

  typedef struct packed {
    sdgc_state_e st;
    logic        busy;
    logic        ack;
    logic [31:0] rdat;
    logic        go_bit;
    logic [1:0]  en;
    logic [4:0]  prog5;
    logic [4:0]  act5;
    logic [4:0]  prog4;
    logic [4:0]  act4;
    logic [1:0]  aln;
    logic [1:0]  chg;
    logic [1:0]  applied;
    logic [4:0]  cnt5;
    logic [5:0]  cnt4;
    logic        tick5;
    logic        tick4;
    logic [1:0]  ist;
    logic [1:0]  imsk;
    logic        irq;
  } sdgc_st_s;

endpackage : sdgc_pkg

// ---- verilog/sdgc_top.sv ----
// fourth and fifth system clock dividers, go command, status, alignment and flags
// assumes clk is the divider source and a classic wishbone master
//
// Implementation choice: the Wishbone slave port.
module sdgc_top
  import sdgc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  other_clocks_on,
  output logic             fifth_system_clock,
  output logic             fourth_system_clock,
  output logic             go_status_bit,
  output logic             irq
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] sdgc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : sdgc_merge

  function automatic logic [31:0] sdgc_div_img(input logic       en,
                                               input logic [4:0] ratio);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[SDGC_EN_POS] = en;
    v[4:0] = ratio;
    return v;
  endfunction : sdgc_div_img

  sdgc_wb_req_s req;
  sdgc_st_s     s_reg;
  sdgc_st_s     s_next;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic        take;
    logic        wr;
    logic        start;
    logic [31:0] v;
    logic [1:0]  set_chg;
    logic        align;
    logic        done;
    take    = 1'b0;
    wr      = 1'b0;
    start   = 1'b0;
    v       = 32'h0000_0000;
    set_chg = 2'b00;
    align   = 1'b0;
    done    = 1'b0;
    s_next  = s_reg;

    // one-cycle wait state: ack follows the request by one edge
    take = req.cyc & req.stb & ~s_reg.ack;
    wr   = take & req.we;
    s_next.ack = take;

    // divider counters; a disabled divider clears its counter to zero and gives no ticks
    if (s_reg.en[1]) begin
      s_next.cnt5  = (s_reg.cnt5 >= s_reg.act5) ? 5'h0_0 : s_reg.cnt5 + 5'h0_1;
      s_next.tick5 = (s_reg.cnt5 >= s_reg.act5);
    end else begin
      s_next.cnt5  = 5'h0_0;
      s_next.tick5 = 1'b0;
    end
    if (s_reg.en[0]) begin
      s_next.cnt4  = (s_reg.cnt4 >= {s_reg.act4, 1'b1}) ? 6'h0_0 : s_reg.cnt4 + 6'h0_1;
      s_next.tick4 = (s_reg.cnt4 >= {s_reg.act4, 1'b1});
    end else begin
      s_next.cnt4  = 6'h0_0;
      s_next.tick4 = 1'b0;
    end

    // read image; reserved bits stay zero
    if (take) begin
      case (req.adr)
        SDGC_ADDR_CMD:   s_next.rdat = {31'h0, s_reg.go_bit};
        SDGC_ADDR_STAT:  s_next.rdat = {31'h0, s_reg.busy};
        SDGC_ADDR_ALN:   s_next.rdat = {27'h0, s_reg.aln, 3'h0};
        SDGC_ADDR_CHG:   s_next.rdat = {27'h0, s_reg.chg, 3'h0};
        SDGC_ADDR_CLKON: begin
          s_next.rdat    = {27'h0, s_reg.en, other_clocks_on, 1'b0};
          s_next.rdat[0] = 1'b1;
        end
        SDGC_ADDR_DIV4:  s_next.rdat = sdgc_div_img(s_reg.en[0], s_reg.prog4);
        SDGC_ADDR_DIV5:  s_next.rdat = sdgc_div_img(s_reg.en[1], s_reg.prog5);
        SDGC_ADDR_IST:   s_next.rdat = {30'h0, s_reg.ist};
        SDGC_ADDR_IMSK:  s_next.rdat = {30'h0, s_reg.imsk};
        default:         s_next.rdat = 32'h0000_0000;
      endcase
    end

    // go sequence runs before writes so a write's flag set wins
    case (s_reg.st)
      SDGC_ST_IDLE: begin
      end
      SDGC_ST_APPLY: begin
        s_next.applied = s_reg.chg;
        if (s_reg.chg[1]) begin
          s_next.act5 = s_reg.prog5;
          align = align | s_reg.aln[1];
          if (s_reg.cnt5 > s_reg.prog5) begin
            s_next.cnt5 = 5'h0_0;
          end
        end
        if (s_reg.chg[0]) begin
          s_next.act4 = s_reg.prog4;
          align = align | s_reg.aln[0];
          if (s_reg.cnt4 > {s_reg.prog4, 1'b1}) begin
            s_next.cnt4 = 6'h0_0;
          end
        end
        // restart both counters together so edges line up
        if (align) begin
          s_next.cnt5 = 5'h0_0;
          s_next.cnt4 = 6'h0_0;
        end
        s_next.st = SDGC_ST_DONE;
      end
      SDGC_ST_DONE: begin
        s_next.chg = s_reg.chg & ~s_reg.applied;
        done = 1'b1;
        s_next.st = SDGC_ST_IDLE;
      end
      default: begin
        s_next.st = SDGC_ST_IDLE;
      end
    endcase

    // interrupt clears, before hardware sets
    if (wr && req.adr == SDGC_ADDR_IST && req.sel[0]) begin
      s_next.ist = s_next.ist & ~req.dat[1:0];
    end
    // done set after the clear so a same-cycle clear cannot lose it
    if (done) begin
      s_next.ist[0] = 1'b1;
    end

    if (wr) begin
      case (req.adr)
        SDGC_ADDR_CMD: begin
          if (req.sel[0]) begin
            s_next.go_bit = req.dat[0];
            start = req.dat[0];
          end
        end
        SDGC_ADDR_ALN: begin
          if (req.sel[0]) begin
            s_next.aln = req.dat[4:3];
          end
        end
        SDGC_ADDR_DIV4: begin
          v = sdgc_merge(sdgc_div_img(s_reg.en[0], s_reg.prog4), req.dat, req.sel);
          s_next.en[0] = v[SDGC_EN_POS];
          s_next.prog4 = v[4:0];
          set_chg[0] = (v[4:0] != s_reg.prog4);
        end
        SDGC_ADDR_DIV5: begin
          v = sdgc_merge(sdgc_div_img(s_reg.en[1], s_reg.prog5), req.dat, req.sel);
          s_next.en[1] = v[SDGC_EN_POS];
          s_next.prog5 = v[4:0];
          set_chg[1] = (v[4:0] != s_reg.prog5);
        end
        default: begin
        end
      endcase
    end

    // a go while one is running is dropped; software must poll first
    if (start && s_reg.st == SDGC_ST_IDLE) begin
      s_next.st = SDGC_ST_APPLY;
    end
    s_next.busy = (s_next.st != SDGC_ST_IDLE);

    s_next.chg = s_next.chg | set_chg;
    // a ratio written while applying was not applied: keep its flag
    s_next.applied = s_next.applied & ~set_chg;
    if (|(set_chg & ~s_reg.chg)) begin
      s_next.ist[1] = 1'b1;
    end
    s_next.irq = |(s_next.ist & s_next.imsk);
    if (wr && req.adr == SDGC_ADDR_IMSK && req.sel[0]) begin
      s_next.imsk = req.dat[1:0];
      s_next.irq  = |(s_next.ist & req.dat[1:0]);
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_reg         <= '0;
      s_reg.st      <= SDGC_ST_IDLE;
      s_reg.en      <= {SDGC_RST_EN, SDGC_RST_EN};
      s_reg.prog5   <= SDGC_RST_RATIO;
      s_reg.act5    <= SDGC_RST_RATIO;
      s_reg.prog4   <= SDGC_RST_RATIO;
      s_reg.act4    <= SDGC_RST_RATIO;
      s_reg.aln     <= SDGC_RST_ALN;
      s_reg.imsk    <= SDGC_RST_IMSK;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o            = s_reg.rdat;
  assign wb_ack_o            = s_reg.ack;
  assign fifth_system_clock  = s_reg.tick5;
  assign fourth_system_clock = s_reg.tick4;
  assign go_status_bit       = s_reg.busy;
  assign irq                 = s_reg.irq;

endmodule : sdgc_top

// ---- bench/sdgc_top_monitor.sv ----
// port assertions for the go control block
// assumes a bind into sdgc_top and a classic wishbone master
module sdgc_mon
  import sdgc_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  other_clocks_on,
  input wire logic        fifth_system_clock,
  input wire logic        go_status_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // helpers and properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic req;
  logic cmd_wr;
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cmd_wr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == SDGC_ADDR_CMD;
  sequence go_busy_s;
    go_status_bit ##1 !go_status_bit;
  endsequence
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_answer_a: assert property (req |=> wb_ack_o) else $error("no ack");
  go_start_a:
    assert property (cmd_wr && wb_dat_i[0] && !go_status_bit |=> go_status_bit)
    else $error("go not started");
  go_length_a:
    assert property ($rose(go_status_bit) |-> ##1 go_busy_s) else $error("go length");
  go_zero_a:
    assert property (cmd_wr && !wb_dat_i[0] && !go_status_bit |=> !go_status_bit)
    else $error("zero write started go");
  stat_zero_a:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i == SDGC_ADDR_STAT
                     |-> wb_dat_o[31:1] == '0) else $error("status reserved bits");
  clock_on_a:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i == SDGC_ADDR_CLKON |-> wb_dat_o[0]
      && wb_dat_o[2:1] == $past(other_clocks_on) && wb_dat_o[31:5] == '0)
    else $error("clock status");
  fifth_off_a:
    assert property (req && wb_we_i && wb_sel_i[1] && wb_adr_i == SDGC_ADDR_DIV5
      && !wb_dat_i[15] |=> ##1 !fifth_system_clock [*4]) else $error("clock not gated");
endmodule : sdgc_mon

bind sdgc_top sdgc_mon mon_u (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .other_clocks_on, .fifth_system_clock,
  .go_status_bit);

// ---- bench/tb_sysclk_divider_go_control.sv ----
// self-checking bench of the go control block
// assumes sdgc_top with the monitor bound in
module tb_sysclk_divider_go_control
  import sdgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // signals and bus tasks
  // ****
  logic         clk = 1'b0;
  logic         reset_n = 1'b0;
  sdgc_wb_req_s req = '0;
  logic [31:0]  dat_o;
  logic         ack, c5, c4, gs, irq;
  int           fail_count = 0;
  int           n_compared = 0;
  always #20 clk = ~clk;
  sdgc_top dut_u (.clk, .reset_n, .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
    .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .other_clocks_on(2'b10), .fifth_system_clock(c5),
    .fourth_system_clock(c4), .go_status_bit(gs), .irq(irq));
  task automatic wb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do @(posedge clk); while (ack !== 1'b1);
    r = dat_o;
    req <= '0;
  endtask : wb
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [31:0] a, exp);
    logic [31:0] r;
    wb(1'b0, a, '0, r);
    chk(r, exp);
  endtask : rd_chk
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr
  // pulse count over a window; mode 1 fourth clock, mode 2 fifth ticks lacking a fourth tick
  task automatic cnt5(input int n, exp, input int mode = 0);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk);
      case (mode)
        1: k += int'(c4 === 1'b1);
        2: k += int'(c5 === 1'b1 && c4 !== 1'b1);
        default: k += int'(c5 === 1'b1);
      endcase
    end
    chk(32'(k), 32'(exp));
  endtask : cnt5
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rd_chk(SDGC_ADDR_STAT, 32'h0000_0000);
    rd_chk(SDGC_ADDR_CHG, 32'h0000_0000);
    rd_chk(SDGC_ADDR_CLKON, 32'h0000_001d);
    wr(SDGC_ADDR_CLKON, 32'h0000_0000);
    rd_chk(SDGC_ADDR_CLKON, 32'h0000_001d);
    wr(SDGC_ADDR_ALN, 32'hffff_ffff);
    rd_chk(SDGC_ADDR_ALN, 32'h0000_0018);
    rd_chk(32'h029a_0148, 32'h0000_0000);
    cnt5(8, 8);
    $display("reset test done");
  endtask : t_reset
  task automatic t_go;
    wr(SDGC_ADDR_DIV5, 32'h0000_8003);
    wr(SDGC_ADDR_DIV4, 32'h0000_8000);
    rd_chk(SDGC_ADDR_CHG, 32'h0000_0010);
    cnt5(8, 8);
    rd_chk(SDGC_ADDR_STAT, 32'h0000_0000);
    wr(SDGC_ADDR_CMD, 32'h0000_0001);
    chk({31'h0, gs}, 32'h0000_0001);
    rd_chk(SDGC_ADDR_STAT, 32'h0000_0000);
    rd_chk(SDGC_ADDR_CHG, 32'h0000_0000);
    rd_chk(SDGC_ADDR_CMD, 32'h0000_0001);
    cnt5(40, 10);
    cnt5(40, 20, 1);
    cnt5(40, 0, 2);
    wr(SDGC_ADDR_CMD, 32'h0000_0000);
    rd_chk(SDGC_ADDR_CMD, 32'h0000_0000);
    cnt5(40, 10);
    $display("go test done");
  endtask : t_go
  task automatic t_enable;
    wr(SDGC_ADDR_DIV5, 32'hffff_0003);
    rd_chk(SDGC_ADDR_DIV5, 32'h0000_0003);
    rd_chk(SDGC_ADDR_CLKON, 32'h0000_000d);
    rd_chk(SDGC_ADDR_CHG, 32'h0000_0000);
    cnt5(20, 0);
    wr(SDGC_ADDR_DIV5, 32'h0000_8003);
    cnt5(40, 10);
    $display("enable test done");
  endtask : t_enable
  task automatic t_irq;
    wr(SDGC_ADDR_IMSK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(SDGC_ADDR_IST, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    rd_chk(SDGC_ADDR_IST, 32'h0000_0002);
    wr(SDGC_ADDR_IST, 32'h0000_0002);
    rd_chk(SDGC_ADDR_IST, 32'h0000_0000);
    $display("interrupt test done");
  endtask : t_irq
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_go;
    t_enable;
    t_irq;
    final_report;
  end
  // the tests need well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    final_report;
  end
endmodule : tb_sysclk_divider_go_control
